// ### hdl/scp_serial_control_port.sv
`timescale 1ns/1ps
module scp_serial_control_port (
  // System clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Strap and serial pins
  input wire logic i_interface_select_pin,
  input wire logic i_control_clock,
  input wire logic i_chip_select_n,
  input wire logic i_serial_data_in,
  output logic o_serial_data_out,
  output logic o_serial_data_out_oe,
  output logic o_irq_n_out,
  output logic o_irq_n_oe,
  // Status toward the transceiver core
  output logic o_port_enabled,
  output logic o_phase_mode_b,
  // Register writes received from the host
  output logic o_wr_valid,
  output logic o_wr_wide,
  output logic [6:0] o_wr_addr,
  output logic [11:0] o_wr_data,
  // Read-back requests received from the host
  output logic o_rb_valid,
  output logic [6:0] o_rb_addr,
  // Messages the core wants to send to the host
  input wire logic i_msg_valid,
  input wire logic i_msg_wide,
  input wire logic i_msg_readback,
  input wire logic [6:0] i_msg_addr,
  input wire logic [11:0] i_msg_data,
  output logic o_msg_ready,
  output logic o_msg_sent
);
  import scp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic link_clr;
  logic [4:0] pos_cnt_q;
  logic [4:0] neg_cnt_q;
  logic [5:0] edge_idx;
  logic frame_live;
  logic sample_now;
  logic [15:0] rx_pos_q;
  logic [15:0] rx_neg_q;
  logic done_pos_q;
  logic done_neg_q;
  logic [5:0] shift_cnt;
  logic [4:0] tx_idx;
  logic [3:0] sync_out;
  logic cs_n_s;
  logic strap_s;
  logic done_pos_s;
  logic done_neg_s;
  logic done_pos_seen_q;
  logic done_neg_seen_q;
  logic frame_evt;
  logic [15:0] rx_word;
  logic [2:0] strap_cnt_q;
  logic port_en_q;
  logic mode_b_q;
  logic [15:0] frame_word_q;
  scp_tx_state_t tx_state_q;
  logic msg_take;

  // ----------------------------------------------------------------
  // Link domain: edge counting on both clock edges
  // ----------------------------------------------------------------
  // Counters clear whenever chip select is high, so a frame always
  // starts from edge zero no matter where the clock rests.
  assign link_clr = i_sys_rst | i_chip_select_n;
  assign edge_idx = {1'b0, pos_cnt_q} + {1'b0, neg_cnt_q};
  assign frame_live = (edge_idx < SCP_EDGES);
  assign sample_now = ~edge_idx[0] ^ mode_b_q;

  always_ff @(posedge i_control_clock or posedge link_clr) begin
    if (link_clr) begin
      pos_cnt_q <= SCP_CNT_ZERO;
    end else if (frame_live) begin
      pos_cnt_q <= pos_cnt_q + SCP_CNT_ONE;
    end
  end

  always_ff @(negedge i_control_clock or posedge link_clr) begin
    if (link_clr) begin
      neg_cnt_q <= SCP_CNT_ZERO;
    end else if (frame_live) begin
      neg_cnt_q <= neg_cnt_q + SCP_CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: input capture, one shift register per edge
  // ----------------------------------------------------------------
  // All samples of one frame land on the same edge type, so the
  // system side later picks one of the two registers whole.
  // capture gated by select
  always_ff @(posedge i_control_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_pos_q <= SCP_WORD_ZERO;
    end else if (!i_chip_select_n && frame_live && sample_now) begin
      rx_pos_q <= {rx_pos_q[14:0], i_serial_data_in};
    end
  end

  always_ff @(negedge i_control_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_neg_q <= SCP_WORD_ZERO;
    end else if (!i_chip_select_n && frame_live && sample_now) begin
      rx_neg_q <= {rx_neg_q[14:0], i_serial_data_in};
    end
  end

  always_ff @(posedge i_control_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      done_pos_q <= 1'b0;
    end else if (!i_chip_select_n && edge_idx == SCP_LAST_EDGE) begin
      done_pos_q <= ~done_pos_q;
    end
  end

  always_ff @(negedge i_control_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      done_neg_q <= 1'b0;
    end else if (!i_chip_select_n && edge_idx == SCP_LAST_EDGE) begin
      done_neg_q <= ~done_neg_q;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: output bit selection
  // ----------------------------------------------------------------
  // The output must change on either clock edge, so the bit is
  // picked from the edge counters rather than from one flip-flop.
  // the edges between samples shift out
  always_comb begin
    shift_cnt = edge_idx;
    if (mode_b_q) begin
      shift_cnt = (edge_idx == SCP_EDGE_ZERO) ? SCP_EDGE_ZERO :
                  edge_idx - SCP_EDGE_ONE;
    end
    tx_idx = shift_cnt[5:1];
    if (tx_idx > SCP_IDX_MAX) begin
      tx_idx = SCP_IDX_MAX;
    end
  end

  assign o_serial_data_out = frame_word_q[SCP_IDX_MAX[3:0] - tx_idx[3:0]];
  assign o_serial_data_out_oe = port_en_q & ~i_chip_select_n;

  // ----------------------------------------------------------------
  // Crossing into the system domain
  // ----------------------------------------------------------------
  scp_sync3 #(
    .W(4),
    .RST_VAL(4'h1)
  ) u_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async({done_neg_q, done_pos_q, i_interface_select_pin,
              i_chip_select_n}),
    .o_level(sync_out)
  );

  assign cs_n_s = sync_out[0];
  assign strap_s = sync_out[1];
  assign done_pos_s = sync_out[2];
  assign done_neg_s = sync_out[3];

  // Remember toggle levels to turn them into frame events
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      done_pos_seen_q <= 1'b0;
      done_neg_seen_q <= 1'b0;
    end else begin
      done_pos_seen_q <= done_pos_s;
      done_neg_seen_q <= done_neg_s;
    end
  end

  assign frame_evt = port_en_q &
                     ((done_pos_s ^ done_pos_seen_q) |
                      (done_neg_s ^ done_neg_seen_q));

  // pick the sampling edge
  // In mode B the last edge samples; in mode A the edge before it.
  always_comb begin
    if ((done_pos_s ^ done_pos_seen_q) == mode_b_q) begin
      rx_word = rx_pos_q;
    end else begin
      rx_word = rx_neg_q;
    end
  end

  // ----------------------------------------------------------------
  // Interface strap
  // ----------------------------------------------------------------
  // strap caught after release
  // Counter stops one past the wait: the strap is taken once, only
  // after the filtered level has had time to follow the pin.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      strap_cnt_q <= 3'h0;
      port_en_q <= 1'b0;
    end else if (strap_cnt_q <= SCP_STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 3'h1;
      if (strap_cnt_q == SCP_STRAP_WAIT) begin
        port_en_q <= strap_s;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_port_enabled <= 1'b0;
    end else begin
      o_port_enabled <= port_en_q;
    end
  end

  // ----------------------------------------------------------------
  // Received message decode
  // ----------------------------------------------------------------
  // Writes and read-back requests leave as one-cycle pulses.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_wr_valid <= 1'b0;
      o_wr_wide <= 1'b0;
      o_wr_addr <= SCP_ADDR_ZERO;
      o_wr_data <= SCP_DATA_ZERO;
      o_rb_valid <= 1'b0;
      o_rb_addr <= SCP_ADDR_ZERO;
    end else begin
      o_wr_valid <= 1'b0;
      o_rb_valid <= 1'b0;
      if (frame_evt) begin
        if (rx_word[SCP_ADDR4_MSB:SCP_ADDR4_LSB] >= SCP_WIDE_NIB_MIN) begin
          o_wr_valid <= 1'b1;
          o_wr_wide <= 1'b1;
          o_wr_addr <= {3'h0, rx_word[SCP_ADDR4_MSB:SCP_ADDR4_LSB]};
          o_wr_data <= rx_word[SCP_DATA12_MSB:0];
        end else if (!rx_word[SCP_FLAG_BIT]) begin
          o_wr_valid <= 1'b1;
          o_wr_wide <= 1'b0;
          o_wr_addr <= rx_word[SCP_ADDR7_MSB:SCP_ADDR7_LSB];
          o_wr_data <= {4'h0, rx_word[SCP_DATA8_MSB:0]};
        end else begin
          o_rb_valid <= 1'b1;
          o_rb_addr <= rx_word[SCP_ADDR7_MSB:SCP_ADDR7_LSB];
        end
      end
    end
  end

  // phase mode register
  // Changes take hold from the next chip-select window onward.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      mode_b_q <= 1'b0;
    end else if (frame_evt && !rx_word[SCP_FLAG_BIT] &&
                 rx_word[SCP_ADDR4_MSB:SCP_ADDR4_LSB] < SCP_WIDE_NIB_MIN &&
                 rx_word[SCP_ADDR7_MSB:SCP_ADDR7_LSB] == SCP_PHASE_SEL_ADDR)
    begin
      mode_b_q <= rx_word[SCP_PHASE_BIT];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_phase_mode_b <= 1'b0;
    end else begin
      o_phase_mode_b <= mode_b_q;
    end
  end

  // ----------------------------------------------------------------
  // Transmit message and interrupt request
  // ----------------------------------------------------------------
  // The frame word is loaded while chip select is seen high and cleared after a frame's last edge, so
  // the link side reads it as a steady value during a frame.
  assign msg_take = i_msg_valid & o_msg_ready;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_msg_ready <= 1'b0;
    end else begin
      o_msg_ready <= port_en_q && cs_n_s && !msg_take &&
                     tx_state_q == SCP_TX_IDLE;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      frame_word_q <= SCP_WORD_ZERO;
    end else if (msg_take) begin
      if (i_msg_wide) begin
        frame_word_q <= {i_msg_addr[3:0], i_msg_data};
      end else begin
        frame_word_q <= {i_msg_addr, i_msg_readback, i_msg_data[7:0]};
      end
    end else if (frame_evt && tx_state_q == SCP_TX_SENT) begin
      frame_word_q <= SCP_WORD_ZERO;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      tx_state_q <= SCP_TX_IDLE;
    end else begin
      case (tx_state_q)
        SCP_TX_IDLE: begin
          if (msg_take) begin
            tx_state_q <= SCP_TX_LOADED;
          end
        end
        SCP_TX_LOADED: begin
          if (cs_n_s) begin
            tx_state_q <= SCP_TX_REQ;
          end else begin
            tx_state_q <= SCP_TX_SENT;
          end
        end
        SCP_TX_REQ: begin
          if (!cs_n_s) begin
            tx_state_q <= SCP_TX_SENT;
          end
        end
        SCP_TX_SENT: begin
          // A window closed short of a full frame asks again
          if (frame_evt) begin
            tx_state_q <= SCP_TX_IDLE;
          end else if (cs_n_s) begin
            tx_state_q <= SCP_TX_REQ;
          end
        end
        default: begin
          tx_state_q <= SCP_TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_msg_sent <= 1'b0;
    end else begin
      o_msg_sent <= frame_evt && tx_state_q == SCP_TX_SENT;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_irq_n_oe <= 1'b0;
    end else if (!port_en_q || !cs_n_s) begin
      o_irq_n_oe <= 1'b0;
    end else if (tx_state_q == SCP_TX_LOADED ||
                 tx_state_q == SCP_TX_REQ) begin
      o_irq_n_oe <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_irq_n_out <= 1'b0;
    end else begin
      o_irq_n_out <= 1'b0;
    end
  end

endmodule : scp_serial_control_port

// ### shared/scp_pkg.sv
package scp_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  // Bits in one chip-select window and clock edges that carry them
  localparam int SCP_FRAME_BITS = 16;
  localparam logic [5:0] SCP_EDGES = 6'h20;
  localparam logic [5:0] SCP_LAST_EDGE = 6'h1f;
  localparam logic [5:0] SCP_EDGE_ZERO = 6'h00;
  localparam logic [5:0] SCP_EDGE_ONE = 6'h01;
  localparam logic [4:0] SCP_CNT_ZERO = 5'h00;
  localparam logic [4:0] SCP_CNT_ONE = 5'h01;
  localparam logic [4:0] SCP_IDX_MAX = 5'h0f;

  // ----------------------------------------------------------------
  // Message field layout, bit 15 is the first bit on the wire
  // ----------------------------------------------------------------
  localparam int SCP_ADDR7_MSB = 15;
  localparam int SCP_ADDR7_LSB = 9;
  localparam int SCP_FLAG_BIT = 8;
  localparam int SCP_DATA8_MSB = 7;
  localparam int SCP_ADDR4_MSB = 15;
  localparam int SCP_ADDR4_LSB = 12;
  localparam int SCP_DATA12_MSB = 11;

  // Upper nibbles at or above this value carry 12-bit messages
  localparam logic [3:0] SCP_WIDE_NIB_MIN = 4'hc;

  // Address of the phase-select register and its mode bit
  localparam logic [6:0] SCP_PHASE_SEL_ADDR = 7'h3f;
  localparam int SCP_PHASE_BIT = 0;

  // Cycles to wait after reset before the strap is trusted
  localparam logic [2:0] SCP_STRAP_WAIT = 3'h4;

  // Reset values
  localparam logic [15:0] SCP_WORD_ZERO = 16'h0000;
  localparam logic [11:0] SCP_DATA_ZERO = 12'h000;
  localparam logic [6:0] SCP_ADDR_ZERO = 7'h00;

  // Transmit message state, Gray coded along the usual path
  typedef enum logic [1:0] {
    SCP_TX_IDLE = 2'b00,
    SCP_TX_LOADED = 2'b01,
    SCP_TX_REQ = 2'b11,
    SCP_TX_SENT = 2'b10
  } scp_tx_state_t;

endpackage : scp_pkg

// ### hdl/scp_sync3.sv
`timescale 1ns/1ps
module scp_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // System side
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Asynchronous levels in, filtered levels out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);

  logic [W-1:0] meta_q;
  logic [W-1:0] stage2_q;
  logic [W-1:0] stage3_q;
  logic [W-1:0] agree;

  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  // ----------------------------------------------------------------
  assign agree = ~(stage2_q ^ stage3_q);

  // First stage is read by the second stage only
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      meta_q <= RST_VAL;
      stage2_q <= RST_VAL;
      stage3_q <= RST_VAL;
    end else begin
      meta_q <= i_async;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
    end
  end

  // Output follows only settled bits
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_level <= RST_VAL;
    end else begin
      o_level <= (o_level & ~agree) | (stage3_q & agree);
    end
  end

endmodule : scp_sync3

// ### test/scp_port_checker_assertions.sv
`timescale 1ns/1ps
module scp_port_checker (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Watched pins and status
  input wire logic i_chip_select_n,
  input wire logic i_msg_valid,
  input wire logic o_serial_data_out_oe,
  input wire logic o_irq_n_out,
  input wire logic o_irq_n_oe,
  input wire logic o_port_enabled,
  input wire logic o_phase_mode_b,
  input wire logic o_wr_valid,
  input wire logic o_wr_wide,
  input wire logic [6:0] o_wr_addr,
  input wire logic [11:0] o_wr_data,
  input wire logic o_rb_valid,
  input wire logic o_msg_ready
);
  import scp_pkg::*;
  // ----------------------------------------------------------------
  // Port properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);
  chk_out_float: assert property (
    i_chip_select_n |-> !o_serial_data_out_oe)
    else $error("serial out driven while deselected");
  chk_oe_frame: assert property (
    !i_chip_select_n && o_port_enabled |-> o_serial_data_out_oe)
    else $error("serial out not driven in frame");
  chk_irq_low_only: assert property (
    o_irq_n_oe |-> !o_irq_n_out)
    else $error("interrupt pin driven high");
  // Sync delay on chip select allows a short grace window
  chk_irq_defer: assert property (
    (!i_chip_select_n) [*6] |-> !$rose(o_irq_n_oe))
    else $error("interrupt fell while selected");
  chk_irq_hold: assert property (
    i_chip_select_n [*8] ##0 o_irq_n_oe |=> o_irq_n_oe)
    else $error("interrupt dropped without chip select");
  chk_irq_release: assert property (
    $fell(i_chip_select_n) |-> ##[0:6] !o_irq_n_oe)
    else $error("interrupt kept after chip select");
  chk_irq_take: assert property (
    i_msg_valid && o_msg_ready && i_chip_select_n ##1 i_chip_select_n
    |=> o_irq_n_oe)
    else $error("no interrupt after message taken");
  chk_strap_gate: assert property (
    !o_port_enabled |-> !o_serial_data_out_oe && !o_irq_n_oe)
    else $error("pins active with port disabled");
  chk_phase_set: assert property (
    o_wr_valid && !o_wr_wide && o_wr_addr == SCP_PHASE_SEL_ADDR
    && o_wr_data[SCP_PHASE_BIT] |-> ##[0:2] o_phase_mode_b)
    else $error("phase select write not applied");
  chk_phase_cause: assert property (
    $rose(o_phase_mode_b) |-> o_wr_valid || $past(o_wr_valid)
    || $past(o_wr_valid, 2))
    else $error("phase mode changed without write");
  chk_flag_excl: assert property (
    o_rb_valid |-> !o_wr_valid)
    else $error("read-back also reported as write");
endmodule : scp_port_checker

bind scp_serial_control_port scp_port_checker u_chk (.*);

// ### test/scp_host_model.sv
`timescale 1ns/1ps
module scp_host_model (
  // Serial pins toward the device
  output logic o_control_clock,
  output logic o_chip_select_n,
  output logic o_serial_data_in,
  input wire logic i_serial_data_out,
  input wire logic i_serial_data_out_oe
);
  // Quarter of the 125 ns link clock period
  localparam realtime QTR = 31.25;
  logic oe_lost = 1'b0;
  // Idle host: deselected, clock still
  initial begin
    o_control_clock = 1'b0;
    o_chip_select_n = 1'b1;
    o_serial_data_in = 1'b1;
  end
  // Chip select alone, for a window with no clocks
  task automatic select(input logic v);
    #1;
    o_chip_select_n = v;
  endtask : select
  // ----------------------------------------------------------------
  // Frame
  // ----------------------------------------------------------------
  // sixteen pulses, MSB first
  task automatic frame(input logic pol, mb, input logic [15:0] tx,
      output logic [15:0] rx);
    int e;
    logic smp;
    rx = 16'h0000;
    oe_lost = 1'b0;
    o_control_clock = pol;
    #(QTR);
    o_chip_select_n = 1'b0;
    for (e = 1; e <= 32; e++) begin
      smp = e[0] ^ mb;
      #(QTR);
      if (smp) o_serial_data_in = tx[15 - (e - 1) / 2];
      #(QTR);
      if (smp) rx[15 - (e - 1) / 2] = i_serial_data_out;
      if (i_serial_data_out_oe !== 1'b1) oe_lost = 1'b1;
      o_control_clock = ~o_control_clock;
    end
    #(QTR);
    o_chip_select_n = 1'b1;
    // Released line shows a changed level, not the last bit
    o_serial_data_in = ~o_serial_data_in;
  endtask : frame
endmodule : scp_host_model

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import scp_pkg::*;
  logic i_clock, i_sys_rst, i_interface_select_pin, i_control_clock;
  logic i_chip_select_n, i_serial_data_in, o_serial_data_out;
  logic o_serial_data_out_oe, o_irq_n_out, o_irq_n_oe, o_port_enabled;
  logic o_phase_mode_b, o_wr_valid, o_wr_wide, o_rb_valid, o_msg_ready;
  logic o_msg_sent, i_msg_valid, i_msg_wide, i_msg_readback;
  logic [6:0] o_wr_addr, o_rb_addr, i_msg_addr, rb_last;
  logic [11:0] o_wr_data, i_msg_data;
  logic [19:0] wr_last;
  logic [15:0] rx;
  int errors = 0, cmp_count = 0, wr_n = 0, rb_n = 0, sent_n = 0;

  scp_serial_control_port dut (.*);
  scp_host_model host (
    .o_control_clock(i_control_clock),
    .o_chip_select_n(i_chip_select_n),
    .o_serial_data_in(i_serial_data_in),
    .i_serial_data_out(o_serial_data_out),
    .i_serial_data_out_oe(o_serial_data_out_oe)
  );
  // System clock, 4 ns
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  // Record decoded traffic, the pulses last one cycle only
  always @(posedge i_clock) begin
    if (o_wr_valid === 1'b1) begin
      wr_n++;
      wr_last = {o_wr_wide, o_wr_addr, o_wr_data};
    end
    if (o_rb_valid === 1'b1) begin
      rb_n++;
      rb_last = o_rb_addr;
    end
    if (o_msg_sent === 1'b1) sent_n++;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [19:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // Bounded wait for the interrupt level
  task automatic wait_irq(input logic v);
    int n;
    for (n = 0; n < 40 && o_irq_n_oe !== v; n++) @(posedge i_clock);
    chk(20'(o_irq_n_oe), 20'(v));
    if (n == 40) conclude();
  endtask : wait_irq
  // Hold the message until the edge that takes it
  task automatic offer(input logic wide, rb, input logic [6:0] a,
      input logic [11:0] d);
    int n;
    @(posedge i_clock);
    #1;
    {i_msg_valid, i_msg_wide, i_msg_readback} = {1'b1, wide, rb};
    {i_msg_addr, i_msg_data} = {a, d};
    @(posedge i_clock);
    for (n = 0; n < 40 && o_msg_ready !== 1'b1; n++) @(posedge i_clock);
    #1;
    i_msg_valid = 1'b0;
    if (n == 40) begin
      errors++;
      conclude();
    end
  endtask : offer
  task automatic xfer(input logic mb, pol, input logic [15:0] tx, exp);
    host.frame(pol, mb, tx, rx);
    chk(20'(rx), 20'(exp));
    chk(20'(host.oe_lost), 20'h0);
    repeat (12) @(posedge i_clock);
  endtask : xfer
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    int n;
    for (n = 0; n < 20 && o_port_enabled !== 1'b1; n++) @(posedge i_clock);
    chk(20'(o_port_enabled), 20'h1);
    chk(20'(o_phase_mode_b), 20'h0);
    chk(20'({o_serial_data_out_oe, o_irq_n_oe}), 20'h0);
    repeat (10) @(posedge i_clock);
  endtask : t_reset
  task automatic t_write(input logic pol, input logic [15:0] tx,
      input logic [19:0] exp);
    int n;
    n = wr_n;
    xfer(1'b0, pol, tx, 16'h0000);
    chk(20'(wr_n - n), 20'h1);
    chk(wr_last, exp);
  endtask : t_write
  task automatic t_readback();
    int w, r;
    w = wr_n;
    r = rb_n;
    xfer(1'b0, 1'b1, {7'h22, 1'b1, 8'haa}, 16'h0000);
    chk(20'(rb_n - r), 20'h1);
    chk(20'({rb_last, 7'(wr_n - w)}), 20'h01100);
  endtask : t_readback
  task automatic t_msg(input logic mb, wide, rb, abort,
      input logic [6:0] a, input logic [11:0] d, input logic [15:0] exp);
    int s;
    s = sent_n;
    offer(wide, rb, a, d);
    wait_irq(1'b1);
    if (abort) begin
      host.select(1'b0);
      repeat (20) @(posedge i_clock);
      chk(20'(o_irq_n_oe), 20'h0);
      host.select(1'b1);
      wait_irq(1'b1);
    end
    xfer(mb, ~rb, 16'h2055, exp);
    chk(20'(sent_n - s), 20'h1);
    chk(wr_last, {1'b0, 7'h10, 12'h055});
    wait_irq(1'b0);
  endtask : t_msg
  task automatic t_mode_b();
    t_write(1'b0, 16'h7e01, {1'b0, SCP_PHASE_SEL_ADDR, 12'h001});
    chk(20'(o_phase_mode_b), 20'h1);
    t_msg(1'b1, 1'b0, 1'b0, 1'b0, 7'h31, 12'h0c3, 16'h62c3);
  endtask : t_mode_b
  // Main sequence
  initial begin
    i_sys_rst = 1'b1;
    i_interface_select_pin = 1'b1;
    {i_msg_valid, i_msg_wide, i_msg_readback} = 3'h0;
    {i_msg_addr, i_msg_data} = 19'h00000;
    repeat (3) @(posedge i_clock);
    #1;
    i_sys_rst = 1'b0;
    t_reset();
    t_write(1'b0, 16'h2055, {1'b0, 7'h10, 12'h055});
    t_readback();
    t_write(1'b1, 16'hc123, {1'b1, 7'h0c, 12'h123});
    t_msg(1'b0, 1'b0, 1'b1, 1'b0, 7'h22, 12'h05a, 16'h455a);
    t_msg(1'b0, 1'b1, 1'b0, 1'b1, 7'h0d, 12'habc, 16'hdabc);
    t_mode_b();
    conclude();
  end
endmodule : tb_top
